// File: bench/nrs_far_side.sv
// Far-side model: external peripheral logic holding the reset pin
`timescale 1ns/1ps
`default_nettype none
module nrs_far_side
(
    // Clock
    input wire logic clk,
    // Reset pin as seen by the device
    output logic pin_n
);
    // Pin has a pull-up, so a released pin reads high
    initial pin_n = 1'b1;

    // Pull the pin low for a number of clock cycles, then release
    task automatic hold_low(input int cycles);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (cycles) @(posedge clk);
        pin_n <= 1'b1;
    endtask : hold_low

    // Two low stretches split by one high cycle; neither long enough alone
    task automatic split_low(input int cycles);
        hold_low(cycles);
        hold_low(cycles);
    endtask : split_low
endmodule : nrs_far_side
`default_nettype wire

// File: bench/test_nrs_node_reset_sequencer.sv
// Self-checking bench for the node reset sequencer
`timescale 1ns/1ps
`default_nettype none
module test_nrs_node_reset_sequencer;
    import nrs_pkg::*;
    localparam int INIT_N = 50;
    localparam int PWR_N = 100;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_n;
    // 0 node, 1 global, 2 watchdog, 3 forbidden, 4 param write, 5 io exchange
    logic [5:0] ev = 6'h00;
    logic addr_chan = 1'b0;
    logic ac_mode = 1'b0;
    logic [3:0] cdat = 4'h0;
    // Node mode in the low bits, other bits marked so the readout is visible
    logic [7:0] nvm = 8'hA4;
    nrs_port_t data_out;
    nrs_port_t param_out;
    logic data_strobe;
    logic param_strobe;
    logic por_pulse;
    logic sm_hold;
    logic [7:0] config_out;
    logic no_data_exchange;
    logic serious_fault;
    logic main_bus_en;
    int fails = 0;
    int checked = 0;
    int ds_n = 0;
    int both_n = 0;
    int n;
    int s;
    logic [31:0] rd;
    logic er;

    always #50 clk = ~clk;

    nrs_node_reset_sequencer #(.INIT_CYCLES(INIT_N), .PWR_INIT_CYCLES(PWR_N))
        u_nrs_node_reset_sequencer (
        .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin_n(pin_n), .node_reset_call(ev[0]),
        .global_reset_call(ev[1]), .watchdog_expired(ev[2]), .fsm_forbidden(ev[3]),
        .addr_chan_active(addr_chan), .ac_current_mode(ac_mode),
        .param_write_call(ev[4]), .io_exchange_call(ev[5]), .call_data(cdat),
        .nvm_data(nvm), .data_out(data_out), .param_out(param_out),
        .data_strobe(data_strobe), .param_strobe(param_strobe), .por_pulse(por_pulse),
        .sm_hold(sm_hold), .config_out(config_out), .no_data_exchange(no_data_exchange),
        .serious_fault(serious_fault), .main_bus_en(main_bus_en));

    nrs_far_side u_nrs_far_side (.clk(clk), .pin_n(pin_n));

    always @(posedge clk)
    begin
        if (data_strobe === 1'b1)
            ds_n++;
        if (data_strobe === 1'b1 && param_strobe === 1'b1)
            both_n++;
    end

    task automatic report_and_stop;
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_port(input string what, input nrs_port_t exp, input nrs_port_t got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_port

    // Access ends only when pready is sampled high; bounded by the timeout
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            chk_bit("apb pready", 1'b1, 1'b0);
            report_and_stop();
        end
    endtask : apb

    task automatic fire(input int i, input logic [3:0] d);
        @(posedge clk);
        ev[i] <= 1'b1;
        cdat <= d;
        @(posedge clk);
        ev[i] <= 1'b0;
        #1;
    endtask : fire

    task automatic wait_run(input int bound);
        int k;
        k = 0;
        while (sm_hold !== 1'b0 && k < bound)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_bit("sm_hold released", 1'b0, sm_hold);
        if (k >= bound)
            report_and_stop();
    endtask : wait_run

    // Parameter write first, then io exchange, so outputs leave the safe value
    task automatic prep;
        fire(4, 4'hA);
        fire(5, 4'h5);
        chk_port("param_out", '{level: 4'hA, oe: 1'b1}, param_out);
        chk_port("data_out", '{level: 4'h5, oe: 1'b1}, data_out);
        chk_bit("exchange shown", 1'b0, no_data_exchange);
    endtask : prep

    // No data strobe may occur for a while after an event that must be ignored
    task automatic quiet(input string what, input int cycles);
        s = ds_n;
        repeat (cycles) @(posedge clk);
        #1;
        chk_word(what, s, ds_n);
    endtask : quiet

    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk_port("data_out in reset", PORT_SAFE, data_out);
        chk_port("param_out in reset", PORT_SAFE, param_out);
        n = 0;
        @(posedge clk);
        #1;
        while (por_pulse === 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_bit("por width min", 1'b1, n >= POR_CYC - 1);
        chk_bit("por width max", 1'b1, n <= POR_MAX_CYC);
        wait_run(PWR_N + 20);
        chk_word("power-on strobes", 0, ds_n);
        chk_word("config_out", 32'h0000_00A4, {24'h0, config_out});
        chk_bit("block after power-on", 1'b1, no_data_exchange);
        fire(5, 4'h3);
        chk_port("io refused", PORT_SAFE, data_out);
        apb(1'b0, 8'h10, 32'h0);
        chk_bit("unmapped pslverr", 1'b1, er);
        chk_word("unmapped read", 32'h0, rd);
        prep();
        fire(2, 4'h0);
        quiet("watchdog disabled", 4);
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b0, REG_CTRL, 32'h0);
        chk_word("ctrl readback", 32'h1, rd);
        for (int i = 0; i < 4; i++)
        begin
            prep();
            s = both_n;
            fire(i, 4'h0);
            chk_word("both strobes", 32'h3, {30'h0, data_strobe, param_strobe});
            chk_port("data_out safe", PORT_SAFE, data_out);
            chk_port("param_out safe", PORT_SAFE, param_out);
            chk_bit("sm_hold in init", 1'b1, sm_hold);
            wait_run(INIT_N + 10);
            chk_word("one strobe pair", s + 1, both_n);
            chk_bit("block after reset", 1'b1, no_data_exchange);
        end
        prep();
        @(posedge clk);
        addr_chan <= 1'b1;
        ac_mode <= 1'b1;
        fire(0, 4'h0);
        quiet("calls suppressed", 4);
        chk_bit("main bus off", 1'b0, main_bus_en);
        @(posedge clk);
        addr_chan <= 1'b0;
        ac_mode <= 1'b0;
        fire(1, 4'h0);
        wait_run(INIT_N + 10);
        chk_bit("main bus restored", 1'b1, main_bus_en);
        prep();
        u_nrs_far_side.hold_low(IGNORE_CYC);
        quiet("short low", 20);
        u_nrs_far_side.split_low(IGNORE_CYC - 50);
        quiet("split low", 20);
        fork
            u_nrs_far_side.hold_low(EXEC_CYC + INIT_N + 60);
        join_none
        @(posedge clk);
        n = 0;
        while (data_out.oe !== 1'b0 && n < EXEC_CYC + 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_bit("hi-z by deadline", 1'b1, n <= EXEC_CYC);
        chk_bit("not before ignore time", 1'b1, n >= IGNORE_CYC);
        chk_port("param hi-z", PORT_SAFE, param_out);
        wait_run(INIT_N + 10);
        chk_bit("pin still low", 1'b0, pin_n);
        repeat (40) @(posedge clk);
        #1;
        chk_bit("serious fault", 1'b1, serious_fault);
        repeat (30) @(posedge clk);
        apb(1'b0, REG_STAT, 32'h0);
        chk_word("stat fault bit", 32'h1, (rd >> STAT_FAULT_BIT) & 32'h1);
        apb(1'b1, REG_STAT, 32'h2);
        @(posedge clk);
        #1;
        chk_bit("fault cleared", 1'b0, serious_fault);
        report_and_stop();
    end
endmodule : test_nrs_node_reset_sequencer
`default_nettype wire

// File: verilog/nrs_init_timer.sv
// Down counter timing the initialisation phase
`timescale 1ns/1ps
`default_nettype none
module nrs_init_timer
    import nrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [TMR_W-1:0] load_val,
    output logic done
);
    logic [TMR_W-1:0] cnt;

    always_ff @(posedge clk)
    begin
        if (reset)
            cnt <= '0;
        else if (load)
            cnt <= load_val;
        else if (cnt != '0)
            cnt <= cnt - TMR_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            done <= 1'b0;
        else
            done <= !load && (cnt == TMR_W'(1));
    end
endmodule : nrs_init_timer
`default_nettype wire

// File: verilog/nrs_node_reset_sequencer.sv
// Node reset sequencer: reset sources, safe outputs, init timing, APB regs
// Overview of operation
// - Any reset loads F into data and parameter outputs, drivers high impedance.
// - Non power-on resets pulse data and parameter strobes together.
// - Reset sets exchange block; io calls refused until parameter write clears it.
// - Call or pin reset finishes init and config readout within 2 ms.
// - Power-on init completes within 30 ms, 1000 ms with heavy load.
// - Internal power-on reset pulse lasts 4 to 6 microseconds.
// - Reset calls, enabled watchdog expiry or forbidden state cause logic reset.
// - Addressing channel active with AC input mode suppresses reset-call handling.
// - Pin reset works in all modes; external logic holds pin low long enough.
// - Pin low pulses of at most 35 microseconds are ignored.
// - Output drivers go high impedance within 44 microseconds of pin falling.
// - Pin reset fires at timer expiry; init starts regardless of pin level.
// - Node mode flags serious fault if pin still low after exec plus init.
// - Node mode keeps main bus off after addressing channel; only reset restores.
// - While exchange block is set, show no-data-exchange and await parameter write.
`timescale 1ns/1ps
`default_nettype none
module nrs_node_reset_sequencer
    import nrs_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYC,
    parameter int PWR_INIT_CYCLES = PWR_INIT_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External reset pin
    input wire logic reset_pin_n,
    // Reset sources
    input wire logic node_reset_call,
    input wire logic global_reset_call,
    input wire logic watchdog_expired,
    input wire logic fsm_forbidden,
    input wire logic addr_chan_active,
    input wire logic ac_current_mode,
    // Calls from the main state machine
    input wire logic param_write_call,
    input wire logic io_exchange_call,
    input wire logic [3:0] call_data,
    input wire logic [7:0] nvm_data,
    // Outputs
    output nrs_port_t data_out,
    output nrs_port_t param_out,
    output logic data_strobe,
    output logic param_strobe,
    output logic por_pulse,
    output logic sm_hold,
    output logic [7:0] config_out,
    output logic no_data_exchange,
    output logic serious_fault,
    output logic main_bus_en
);
    nrs_state_t state;
    nrs_state_t next_state;
    nrs_cause_t cause;
    logic pin_low;
    logic ext_trig;
    logic logic_evt;
    logic rst_evt;
    logic tmr_load;
    logic tmr_done;
    logic [TMR_W-1:0] tmr_val;
    logic [7:0] por_cnt;
    logic xchg_block;
    logic wdog_en;
    logic run_ok;
    logic apb_acc;
    logic apb_wr;
    logic [31:0] rd_val;
    logic rd_hit;

    nrs_pin_filter u_pin_filter (
        .clk(clk),
        .reset(reset),
        .pin_n(reset_pin_n),
        .pin_low(pin_low),
        .trig(ext_trig)
    );

    // Reset calls are handled elsewhere while the optical channel uses AC input
    always_comb
    begin
        logic calls_ok;
        calls_ok = !(addr_chan_active && ac_current_mode);
        logic_evt = (state != ST_POR) &&
            (((node_reset_call || global_reset_call) && calls_ok) ||
             (watchdog_expired && wdog_en) || fsm_forbidden);
    end

    // Pin reset is an event at timer expiry, independent of later pin level
    assign rst_evt = logic_evt || (ext_trig && state != ST_POR);

    always_comb
    begin
        next_state = state;
        if (rst_evt)
            next_state = ST_INIT;
        else
        begin
            case (state)
                ST_POR:
                    if (por_cnt == 8'(POR_CYC - 1))
                        next_state = ST_INIT;
                ST_INIT:
                    if (tmr_done)
                        next_state = ST_RUN;
                ST_RUN:
                    next_state = ST_RUN;
                default:
                    next_state = ST_POR;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            state <= ST_POR;
        else
            state <= next_state;
    end

    always_ff @(posedge clk)
    begin
        if (reset || state != ST_POR)
            por_cnt <= '0;
        else
            por_cnt <= por_cnt + 8'(1);
    end

    // Pulse is level of the power-on phase after supply reset release
    always_ff @(posedge clk)
    begin
        if (reset)
            por_pulse <= 1'b1;
        else
            por_pulse <= (next_state == ST_POR);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            sm_hold <= 1'b1;
        else
            sm_hold <= (next_state != ST_RUN);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            cause <= CAUSE_POR;
        else if (ext_trig && state != ST_POR)
            cause <= CAUSE_EXT;
        else if (logic_evt)
            cause <= CAUSE_LOGIC;
    end

    // Timer restarts on any new reset, even mid-initialisation
    assign tmr_load = (next_state == ST_INIT) && (state != ST_INIT || rst_evt);
    assign tmr_val = (state == ST_POR && !rst_evt) ? TMR_W'(PWR_INIT_CYCLES)
                                                   : TMR_W'(INIT_CYCLES);

    nrs_init_timer u_init_timer (
        .clk(clk),
        .reset(reset),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // Config captured as the readout ends, on the same edge that releases the machine
    always_ff @(posedge clk)
    begin
        if (reset)
            config_out <= CFG_RST;
        else if (state == ST_INIT && tmr_done && !rst_evt)
            config_out <= nvm_data;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            serious_fault <= 1'b0;
        else if (state == ST_INIT && tmr_done && !rst_evt && cause == CAUSE_EXT &&
                 pin_low && nvm_data[1:0] == MODE_NODE)
            serious_fault <= 1'b1;
        else if (apb_wr && paddr == REG_STAT && pwdata[STAT_FAULT_BIT])
            serious_fault <= 1'b0;
    end

    // Reset wins over a same-cycle parameter write
    always_ff @(posedge clk)
    begin
        if (reset || rst_evt || state != ST_RUN)
            xchg_block <= 1'b1;
        else if (param_write_call)
            xchg_block <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            no_data_exchange <= 1'b1;
        else
            no_data_exchange <= xchg_block;
    end

    assign run_ok = (state == ST_RUN) && !rst_evt;

    always_ff @(posedge clk)
    begin
        if (reset || rst_evt)
            param_out <= PORT_SAFE;
        else if (run_ok && param_write_call)
            param_out <= '{level: call_data, oe: 1'b1};
    end

    // Io calls are dropped while blocked: the master must write parameters first
    always_ff @(posedge clk)
    begin
        if (reset || rst_evt)
            data_out <= PORT_SAFE;
        else if (run_ok && io_exchange_call && !xchg_block)
            data_out <= '{level: call_data, oe: 1'b1};
    end

    // Power-on enters through reset, so it never reaches this strobe term
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            data_strobe <= 1'b0;
            param_strobe <= 1'b0;
        end
        else
        begin
            data_strobe <= rst_evt || (run_ok && io_exchange_call && !xchg_block);
            param_strobe <= rst_evt || (run_ok && param_write_call);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset || rst_evt)
            main_bus_en <= 1'b1;
        else if (addr_chan_active && config_out[1:0] == MODE_NODE && state == ST_RUN)
            main_bus_en <= 1'b0;
    end

    // APB slave, one wait state
    assign apb_acc = psel && penable;
    assign apb_wr = apb_acc && pready && pwrite;

    always_comb
    begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (paddr)
            REG_CTRL:
                rd_val[CTRL_WDOG_BIT] = wdog_en;
            REG_STAT:
            begin
                rd_val[STAT_XCHG_BIT] = xchg_block;
                rd_val[STAT_FAULT_BIT] = serious_fault;
                rd_val[STAT_BUS_BIT] = main_bus_en;
                rd_val[STAT_BUSY_BIT] = (state != ST_RUN);
                rd_val[STAT_CAUSE_LSB +: 2] = cause;
            end
            REG_CFG:
                rd_val[7:0] = config_out;
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_acc && !pready;
            prdata <= (apb_acc && !pready && !pwrite) ? rd_val : 32'h0000_0000;
            pslverr <= apb_acc && !pready && !rd_hit;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            wdog_en <= CTRL_RST;
        else if (apb_wr && paddr == REG_CTRL)
            wdog_en <= pwdata[CTRL_WDOG_BIT];
    end

    // Helper counters for checks only
    logic [LOW_W-1:0] low_len;
    logic [TMR_W-1:0] init_len;
    logic [7:0] por_len;

    always_ff @(posedge clk)
    begin
        if (reset || reset_pin_n)
            low_len <= '0;
        else if (low_len != '1)
            low_len <= low_len + LOW_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (reset || state != ST_INIT || tmr_load)
            init_len <= '0;
        else
            init_len <= init_len + TMR_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (reset || !por_pulse)
            por_len <= '0;
        else
            por_len <= por_len + 8'(1);
    end

    property p_safe;
        @(posedge clk) disable iff (reset) rst_evt |=> !data_out.oe && !param_out.oe &&
            data_out.level == OUT_SAFE && param_out.level == OUT_SAFE;
    endproperty
    a_safe: assert property (p_safe) else $error("outputs not safe after reset");

    property p_strobe;
        @(posedge clk) disable iff (reset) rst_evt |=> data_strobe && param_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobes missing");

    property p_refuse;
        @(posedge clk) disable iff (reset) io_exchange_call && xchg_block |=> $stable(data_out);
    endproperty
    a_refuse: assert property (p_refuse) else $error("io call not refused");

    property p_init_time;
        @(posedge clk) disable iff (reset) state == ST_INIT |->
            init_len <= TMR_W'(PWR_INIT_CYCLES + 1);
    endproperty
    a_init_time: assert property (p_init_time) else $error("init too long");

    property p_por;
        @(posedge clk) disable iff (reset) $fell(por_pulse) |->
            $past(por_len) >= 8'(POR_CYC - 1) && $past(por_len) <= 8'(POR_MAX_CYC);
    endproperty
    a_por: assert property (p_por) else $error("power-on pulse width");

    property p_ignore;
        @(posedge clk) disable iff (reset) ext_trig |-> low_len > LOW_W'(IGNORE_CYC);
    endproperty
    a_ignore: assert property (p_ignore) else $error("short pin pulse acted on");

    property p_hiz;
        @(posedge clk) disable iff (reset) low_len == LOW_W'(EXEC_CYC) |->
            !data_out.oe && !param_out.oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("drivers not off in time");

    property p_ext_init;
        @(posedge clk) disable iff (reset) ext_trig && state != ST_POR |=> state == ST_INIT;
    endproperty
    a_ext_init: assert property (p_ext_init) else $error("pin reset missed");

    property p_calls_off;
        @(posedge clk) disable iff (reset) state == ST_RUN && node_reset_call &&
            addr_chan_active && ac_current_mode && !watchdog_expired && !fsm_forbidden &&
            !ext_trig |=> state == ST_RUN;
    endproperty
    a_calls_off: assert property (p_calls_off) else $error("call reset not suppressed");

    property p_hold;
        @(posedge clk) disable iff (reset) state != ST_RUN |-> sm_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("machine released early");

    c_ext: cover property (@(posedge clk) disable iff (reset) ext_trig ##[1:3] state == ST_INIT);
    c_logic: cover property (@(posedge clk) disable iff (reset) logic_evt);
    c_fault: cover property (@(posedge clk) disable iff (reset) $rose(serious_fault));
    c_clear: cover property (@(posedge clk) disable iff (reset) $fell(xchg_block));
endmodule : nrs_node_reset_sequencer
`default_nettype wire

// File: verilog/nrs_pin_filter.sv
// External reset pin synchroniser and low-time filter
`timescale 1ns/1ps
`default_nettype none
module nrs_pin_filter
    import nrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pin and result
    input wire logic pin_n,
    output logic pin_low,
    output logic trig
);
    logic meta;
    logic [LOW_W-1:0] cnt;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta <= 1'b1;
            pin_low <= 1'b0;
        end
        else
        begin
            meta <= pin_n;
            pin_low <= ~meta;
        end
    end

    // Counter restarts on every high sample, saturates so one low fires once
    always_ff @(posedge clk)
    begin
        if (reset || !pin_low)
            cnt <= '0;
        else if (cnt != LOW_W'(IGNORE_CYC + 1))
            cnt <= cnt + LOW_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            trig <= 1'b0;
        else
            // Fires on the sample after the ignore window, so a low of exactly that length is ignored
            trig <= pin_low && (cnt == LOW_W'(IGNORE_CYC));
    end
endmodule : nrs_pin_filter
`default_nettype wire

// File: verilog/nrs_pkg.sv
// Package for the node reset sequencer: constants, states and carriers
package nrs_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    // Times in their own units
    localparam int POR_PULSE_NS = 4000;
    localparam int POR_PULSE_MAX_NS = 6000;
    localparam int IGNORE_NS = 35000;
    localparam int EXEC_NS = 44000;
    localparam int INIT_US = 2000;
    localparam int PWR_INIT_US = 30000;
    // Cycle counts
    localparam int POR_CYC = (POR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int POR_MAX_CYC = POR_PULSE_MAX_NS / CLK_NS;
    localparam int IGNORE_CYC = IGNORE_NS / CLK_NS;
    localparam int EXEC_CYC = EXEC_NS / CLK_NS;
    localparam int INIT_CYC = INIT_US * 1000 / CLK_NS;
    localparam int PWR_INIT_CYC = PWR_INIT_US * 1000 / CLK_NS;
    localparam int TMR_W = 24;
    localparam int LOW_W = 12;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam int CTRL_WDOG_BIT = 0;
    localparam int STAT_XCHG_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_BUS_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_CAUSE_LSB = 4;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [3:0] OUT_SAFE = 4'hF;
    localparam logic [1:0] MODE_NODE = 2'h0;
    typedef enum logic [2:0] {
        ST_POR = 3'b001,
        ST_INIT = 3'b010,
        ST_RUN = 3'b100
    } nrs_state_t;
    typedef enum logic [1:0] {
        CAUSE_POR = 2'h0,
        CAUSE_LOGIC = 2'h1,
        CAUSE_EXT = 2'h2
    } nrs_cause_t;
    typedef struct packed {
        logic [3:0] level;
        logic oe;
    } nrs_port_t;
    localparam nrs_port_t PORT_SAFE = '{level: OUT_SAFE, oe: 1'b0};
endpackage : nrs_pkg
